// ==== sim/spi_status_flags_and_pins_tb.sv ====
// testbench of the serial flag block
module spi_status_flags_and_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spisf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_en = 1'b0;
  logic tb_sclk = 1'b0;
  logic tb_mosi = 1'b0;
  logic tb_ss = 1'b1;
  logic [7:0] reply = 8'h0000;
  logic [31:0] lfsr = 32'h5a7a_9767;
  logic [7:0] rd, got, rdata, b, o, a;
  logic [7:0] cs [3];
  spisf_sfr_req_type req = '0;
  spisf_pins_out_type pins;
  wire logic irq, p_miso, sclk, mosi, miso, ss;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int t;
  assign sclk = pins.sclk_oe_n ? tb_sclk : pins.sclk_o;
  assign mosi = pins.mosi_oe_n ? tb_mosi : pins.mosi_o;
  assign miso = pins.miso_oe_n ? p_miso : pins.miso_o;
  assign ss = pins.ss_oe_n ? tb_ss : pins.ss_o;
  spisf_core dut_u (.clk(clk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdata), .serial_irq(irq),
    .serial_irq_enable(irq_en), .link_sclk(sclk), .sclk_i(sclk), .mosi_i(mosi), .miso_i(miso),
    .ss_i(ss), .pins(pins));
  spisf_partner far_u (.sclk(sclk), .mosi(mosi), .ss_n(ss), .miso(p_miso), .reply(reply), .got(got));
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      close_out();
    end
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string w);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic acc(input logic [7:0] ad, input logic [7:0] d, input logic w);
    @(negedge clk);
    req = '{addr: ad, wdata: d, wr: w, rd: !w};
    @(negedge clk);
    req = '0;
    rd = rdata;
  endtask
  task automatic wait_ss();
    int i;
    for (i = 0; i < 600 && ss !== 1'b0; i++) @(negedge clk);
    for (i = 0; i < 600 && ss !== 1'b1; i++) @(negedge clk);
  endtask
  // far master in mode zero, link clock only within the frame
  task automatic slave_xfer(input logic [7:0] d, output logic [7:0] q);
    int k;
    #3 tb_ss = 1'b0;
    #100;
    for (k = 7; k >= 0; k--)
    begin
      tb_mosi = d[k];
      #7.5 tb_sclk = 1'b1;
      q[k] = miso;
      #7.5 tb_sclk = 1'b0;
    end
    #100 tb_ss = 1'b1;
    tb_mosi = ~d[0];
  endtask
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    acc(ADDR_STATUS, 8'h0000, 1'b0);
    chk(rd & 8'h000b, 8'h0002, "status reset");
    acc(ADDR_CONFIG_ONE, 8'h0030, 1'b1);
    acc(ADDR_CONFIG_ONE, 8'h0000, 1'b0);
    chk(rd, 8'h0030, "config one");
    for (t = 0; t < 4; t++)
    begin
      irq_en = t[0];
      b = rnd();
      reply = rnd();
      acc(ADDR_TX, b, 1'b1);
      acc(ADDR_STATUS, 8'h0000, 1'b0);
      chk(rd & 8'h0080, 8'h0080, "busy");
      wait_ss();
      chk(got, b, "mosi byte");
      acc(ADDR_STATUS, 8'h0000, 1'b0);
      chk(rd & 8'h009b, 8'h001a, "rx flags");
      chk({7'h00, irq}, {7'h00, irq_en}, "irq");
      acc(ADDR_RX, 8'h0000, 1'b0);
      chk(rd, reply, "rx byte");
      acc(ADDR_STATUS, 8'h0000, 1'b0);
      chk(rd & 8'h0018, 8'h0000, "rx clear");
    end
    $display("test master done");
    for (t = 0; t < 2; t++)
    begin
      acc(ADDR_CONFIG_TWO, t[0] ? 8'h0011 : 8'h0001, 1'b1);
      reply = rnd();
      a = reply;
      acc(ADDR_TX, rnd(), 1'b1);
      wait_ss();
      reply = rnd();
      acc(ADDR_TX, rnd(), 1'b1);
      wait_ss();
      acc(ADDR_STATUS, 8'h0000, 1'b0);
      chk(rd & 8'h0026, 8'h0026, "overflow");
      acc(ADDR_STATUS, 8'h0000, 1'b0);
      chk(rd & 8'h0004, 8'h0000, "underflow clear");
      acc(ADDR_RX, 8'h0000, 1'b0);
      chk(rd, t[0] ? reply : a, "overwrite");
    end
    $display("test overflow done");
    acc(ADDR_CONFIG_TWO, 8'h0001, 1'b1);
    acc(ADDR_CONFIG_ONE, 8'h0000, 1'b1);
    for (t = 0; t < 3; t++)
    begin
      cs[t] = rnd();
      acc(ADDR_TX, cs[t], 1'b1);
      if (t == 0)
      begin
        acc(ADDR_STATUS, 8'h0000, 1'b0);
        chk(rd & 8'h0003, 8'h0000, "tx irq clear");
      end
    end
    acc(ADDR_STATUS, 8'h0000, 1'b0);
    chk(rd & 8'h0003, 8'h0001, "tx full");
    for (t = 0; t < 2; t++)
    begin
      b = rnd();
      slave_xfer(b, o);
      chk(o, cs[t], "miso byte");
      repeat (4) @(negedge clk);
      acc(ADDR_RX, 8'h0000, 1'b0);
      chk(rd, b, "slave rx");
    end
    acc(ADDR_STATUS, 8'h0000, 1'b0);
    chk(rd & 8'h0003, 8'h0002, "tx empty");
    $display("test slave done");
    close_out();
  end
endmodule // spi_status_flags_and_pins_tb

// ==== sim/spisf_checker.sv ====
// checker: port-level assertions of the serial flag block
module spisf_checker (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire spisf_pkg::spisf_sfr_req_type sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic serial_irq,
  input wire logic serial_irq_enable,
  // pins
  input wire logic ss_i,
  input wire spisf_pkg::spisf_pins_out_type pins
);
  import spisf_pkg::*;
  logic [7:0] cfg1;
  logic [9:0] ss_cnt;
  wire logic m = cfg1[C1_MASTER];
  wire logic rdrx = sfr_req.rd && sfr_req.addr == ADDR_RX;
  wire logic rdst = sfr_req.rd && sfr_req.addr == ADDR_STATUS;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cfg1 <= REG_RESET;
    else if (sfr_req.wr && sfr_req.addr == ADDR_CONFIG_ONE)
      cfg1 <= sfr_req.wdata;
  end
  // length of a low select, master role only
  always_ff @(posedge clk)
  begin
    if (!rst_n || pins.ss_o || !m)
      ss_cnt <= 10'h0000;
    else
      ss_cnt <= ss_cnt + 10'h0001;
  end
  property p_miso_dir;
    m && $past(m) |-> pins.miso_oe_n;
  endproperty
  a_miso_dir: assert property (p_miso_dir) else $error("data-in driven as master");
  property p_miso_out;
    !m && $past(!m) && !ss_i && $past(!ss_i) && $past(!ss_i, 2) |-> !pins.miso_oe_n;
  endproperty
  a_miso_out: assert property (p_miso_out) else $error("data-in not driven as slave");
  property p_mosi_dir;
    m && $past(m) |-> !pins.mosi_oe_n;
  endproperty
  a_mosi_dir: assert property (p_mosi_dir) else $error("data-out not driven as master");
  property p_slave_in;
    !m && $past(!m) |-> pins.mosi_oe_n && pins.sclk_oe_n && pins.ss_oe_n;
  endproperty
  a_slave_in: assert property (p_slave_in) else $error("slave pin driven");
  property p_sclk_dir;
    m && $past(m) |-> !pins.sclk_oe_n;
  endproperty
  a_sclk_dir: assert property (p_sclk_dir) else $error("clock not driven as master");
  property p_cfg_rd;
    sfr_req.rd && !sfr_req.wr && sfr_req.addr == ADDR_CONFIG_ONE |=> sfr_rdata == cfg1;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  property p_irq_off;
    !serial_irq_enable |=> !serial_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
  property p_rxbf_clr;
    rdrx ##2 rdst |=> !sfr_rdata[ST_RXBF];
  endproperty
  a_rxbf_clr: assert property (p_rxbf_clr) else $error("receive full not cleared");
  property p_ss_auto;
    sfr_req.wr && sfr_req.addr == ADDR_TX && m && cfg1[C1_AUTO_SS] && !cfg1[C1_SS_EN] && pins.ss_o
      |-> ##[1:8] !pins.ss_o;
  endproperty
  a_ss_auto: assert property (p_ss_auto) else $error("select not lowered");
  property p_ss_end;
    ss_cnt < 10'h03e8;
  endproperty
  a_ss_end: assert property (p_ss_end) else $error("select not raised");
  c_master: cover property ($fell(pins.ss_o) && m);
  c_slave: cover property ($fell(ss_i) && !m);
  c_ovf: cover property (rdst ##1 sfr_rdata[ST_RXOF]);
endmodule // spisf_checker

bind spisf_core spisf_checker chk_u (.clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .serial_irq(serial_irq), .serial_irq_enable(serial_irq_enable), .ss_i(ss_i), .pins(pins));

// ==== sim/spisf_partner.sv ====
// partner: remote serial slave, clock mode zero
module spisf_partner (
  // serial lines
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso,
  // byte returned and byte seen
  input wire logic [7:0] reply,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h0000;
  logic rel = 1'b0;
  always @(negedge ss_n) sh = reply;
  always @(posedge ss_n) rel = ~reply[0];
  always @(posedge sclk) if (!ss_n) got = {got[6:0], mosi};
  always @(negedge sclk) if (!ss_n) sh = {sh[6:0], 1'b0};
  assign miso = ss_n ? rel : sh[7];
endmodule // spisf_partner

// ==== verilog/spisf_core.sv ====
// serial peripheral flags, pins and shift engine
// Operation
// - with transfer mode cleared, new receive data sets receive interrupt flag; interrupt if enabled
// - receive mode: unread receive register at byte end stops transfer, deasserts select
// - status bit 3 is receive full, cleared by receive read, resets zero
// - status bit 2 is transmit underflow, cleared by status read or transmit write
// - status bit 1 transmit interrupt flag clears on transmit register write in transfer mode
// - transfer mode cleared: transmit flag reads 0 when full, 1 when empty
// - transfer mode set: each byte taken from the buffer sets flag; no new data by byte end stops, deasserts select
// - status bit 0 is transmit buffer full, resets zero
// - data-in pin is input as master, output as slave while select is low
// - data-out pin is output as master, input as slave
// - bytes are eight bits, most significant bit first
// - serial clock pin is output as master, input as slave
// - master rate and polarity from config registers, master ignores phase; slave uses config two
// - launch on one edge, sample on the other; both ends share settings
// - slave select is input in slave mode; low starts, bytes until high
// - automatic select lowers select for transfer and raises it after
// - busy flag set while transferring as master or slave
// - unread receive at next byte end sets overflow; overwrite if enabled
module spisf_core (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // special function register port
  input wire spisf_pkg::spisf_sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  output logic serial_irq,
  input wire logic serial_irq_enable,
  // link clock for slave role
  input wire logic link_sclk,
  // pins
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_i,
  output spisf_pkg::spisf_pins_out_type pins
);
  import spisf_pkg::*;

  function automatic logic sel_bit(input logic [7:0] v, input int pos);
    sel_bit = v[pos];
  endfunction

  logic [7:0] serial_config_one;
  logic [7:0] serial_config_two;
  logic [7:0] receive_register;
  logic rx_irq_flag, rx_overflow_flag, rx_buffer_full, tx_underflow, tx_irq_set;
  logic multi_master_error;
  // two-entry transmit buffer
  logic [7:0] txq [0:1];
  logic txq_wp, txq_rp;
  logic [1:0] txq_cnt;

  wire is_master = sel_bit(serial_config_one, C1_MASTER);
  wire auto_ss = sel_bit(serial_config_one, C1_AUTO_SS);
  wire ss_en = sel_bit(serial_config_one, C1_SS_EN);
  wire transfer_mode_select = sel_bit(serial_config_two, C2_XFER_MODE);
  wire cpha = sel_bit(serial_config_two, C2_CPHA);
  wire cpol = sel_bit(serial_config_two, C2_CPOL);
  wire overflow_overwrite_enable = sel_bit(serial_config_two, C2_OVW);
  wire cont_mode = sel_bit(serial_config_two, C2_CONT);
  wire wr_tx = sfr_req.wr && sfr_req.addr == ADDR_TX;
  wire rd_rx = sfr_req.rd && sfr_req.addr == ADDR_RX;
  wire rd_stat = sfr_req.rd && sfr_req.addr == ADDR_STATUS;
  wire tx_buffer_full = txq_cnt[1];
  wire txq_in_ready = !tx_buffer_full;
  wire txq_out_valid = txq_cnt != 2'b00;
  wire [7:0] txq_head = txq[txq_rp];

  // synchronisers for pins
  logic [1:0] ss_sync, miso_sync;
  always_ff @(posedge clk)
  begin
    ss_sync <= {ss_sync[0], ss_i};
    miso_sync <= {miso_sync[0], miso_i};
  end
  wire ss_in = ss_sync[1];

  // master engine
  typedef enum logic [1:0] {M_IDLE, M_LEAD, M_TRAIL, M_GAP} spisf_mstate_type;
  spisf_mstate_type mstate;
  logic [7:0] div_cnt, m_shift;
  logic [3:0] m_bits;
  logic m_sclk, m_ss, m_done;
  wire [7:0] div_top = DIV_BASE << serial_config_one[C1_DIV_LSB +: C1_DIV_W];
  wire tick = div_cnt == 8'h0000;
  // stop when the required buffer action is missing at a byte end
  wire may_continue = transfer_mode_select ? txq_out_valid : !rx_buffer_full;
  wire m_start = is_master && txq_out_valid && mstate == M_IDLE && !(ss_en && !ss_in);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mstate <= M_IDLE;
      div_cnt <= REG_RESET;
      m_shift <= REG_RESET;
      m_bits <= 4'h0000;
      m_sclk <= 1'b0;
      m_ss <= 1'b1;
      m_done <= 1'b0;
    end
    else
    begin
      m_done <= 1'b0;
      div_cnt <= tick ? div_top : div_cnt - 8'h0001;
      case (mstate)
        M_IDLE:
        begin
          m_sclk <= cpol;
          if (m_start)
          begin
            m_shift <= txq_head;
            m_bits <= 4'h0000;
            m_ss <= !auto_ss;
            mstate <= M_LEAD;
          end
        end
        M_LEAD:
          if (tick)
          begin
            m_sclk <= !m_sclk;
            mstate <= M_TRAIL;
          end
        M_TRAIL:
          if (tick)
          begin
            m_sclk <= !m_sclk;
            m_shift <= {m_shift[6:0], miso_sync[1]};
            m_bits <= m_bits + 4'h0001;
            if (m_bits + 4'h0001 == BIT_COUNT_LAST)
            begin
              m_done <= 1'b1;
              mstate <= M_GAP;
            end
            else
              mstate <= M_LEAD;
          end
        M_GAP:
          if (tick)
          begin
            if (may_continue && txq_out_valid && cont_mode)
            begin
              m_shift <= txq_head;
              m_bits <= 4'h0000;
              mstate <= M_LEAD;
            end
            else
            begin
              m_ss <= 1'b1;
              mstate <= M_IDLE;
            end
          end
        default:
          mstate <= M_IDLE;
      endcase
    end
  end

  // slave engine on link clock; data launched and sampled on opposite edges
  logic [7:0] s_shift, s_byte;
  logic [2:0] s_bits;
  logic s_tgl;
  logic [7:0] s_txbyte;
  logic link_rst;
  wire s_sample_clk = link_sclk ^ cpol ^ cpha;
  // core reset carried to the link side; select clears only the bit position and shift register
  always_ff @(posedge clk)
  begin
    link_rst <= !rst_n;
  end
  always_ff @(posedge s_sample_clk or posedge ss_i)
  begin
    if (ss_i)
    begin
      s_bits <= 3'h0;
      s_shift <= 8'h0000;
    end
    else
    begin
      s_shift <= {s_shift[6:0], mosi_i};
      s_bits <= s_bits + 3'h1;
    end
  end
  // byte and toggle survive select release, so no false byte event follows a frame
  always_ff @(posedge s_sample_clk or posedge link_rst)
  begin
    if (link_rst)
    begin
      s_byte <= REG_RESET;
      s_tgl <= 1'b0;
    end
    else if (s_bits == 3'h7)
    begin
      s_byte <= {s_shift[6:0], mosi_i};
      s_tgl <= !s_tgl;
    end
  end
  // slave launch from bytes taken in the clk domain, held stable per byte
  logic [2:0] s_obits;
  always_ff @(negedge s_sample_clk or posedge ss_i)
  begin
    if (ss_i)
      s_obits <= 3'h0;
    else
      s_obits <= s_bits;
  end
  wire s_miso = s_txbyte[3'h7 - s_obits];

  // slave byte event crossing: toggle through three flops
  logic [2:0] s_tgl_sync;
  logic [7:0] s_byte_q;
  always_ff @(posedge clk)
  begin
    s_tgl_sync <= {s_tgl_sync[1:0], s_tgl};
    s_byte_q <= s_byte;
  end
  wire s_done = !is_master && (s_tgl_sync[2] ^ s_tgl_sync[1]);
  wire byte_done = m_done || s_done;
  wire [7:0] byte_in = is_master ? m_shift : s_byte_q;
  wire master_load = m_start || (mstate == M_GAP && tick && may_continue && txq_out_valid && cont_mode);
  wire slave_load = s_done || (!is_master && ss_in && txq_out_valid && !rx_irq_flag && s_txbyte == 8'h0000);
  wire tx_pop = txq_out_valid && (master_load || s_done);
  wire busy = is_master ? (mstate != M_IDLE) : !ss_in;

  // slave transmit byte, reloaded at byte end or select high; cleared there when the buffer is empty
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_txbyte <= REG_RESET;
    else if (!is_master && (s_done || ss_in))
      s_txbyte <= txq_out_valid ? txq_head : REG_RESET;
  end

  // transmit buffer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      txq_wp <= 1'b0;
      txq_rp <= 1'b0;
      txq_cnt <= 2'b00;
    end
    else
    begin
      if (wr_tx && txq_in_ready)
      begin
        txq[txq_wp] <= sfr_req.wdata;
        txq_wp <= !txq_wp;
      end
      if (tx_pop && !slave_load)
        txq_rp <= !txq_rp;
      else if (tx_pop)
        txq_rp <= !txq_rp;
      txq_cnt <= txq_cnt + {1'b0, wr_tx && txq_in_ready} - {1'b0, tx_pop};
    end
  end

  // flags and configuration
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      serial_config_one <= REG_RESET;
      serial_config_two <= REG_RESET;
      receive_register <= REG_RESET;
      rx_irq_flag <= 1'b0;
      rx_buffer_full <= 1'b0;
      rx_overflow_flag <= 1'b0;
      tx_underflow <= 1'b0;
      tx_irq_set <= 1'b0;
      multi_master_error <= 1'b0;
    end
    else
    begin
      if (sfr_req.wr && sfr_req.addr == ADDR_CONFIG_ONE)
        serial_config_one <= sfr_req.wdata;
      if (sfr_req.wr && sfr_req.addr == ADDR_CONFIG_TWO)
        serial_config_two <= sfr_req.wdata;
      if (byte_done && (!rx_buffer_full || rd_rx || overflow_overwrite_enable))
        receive_register <= byte_in;
      // set wins over clear for every flag except overflow, which a same-cycle receive read clears
      if (byte_done)
      begin
        rx_irq_flag <= 1'b1;
        rx_buffer_full <= 1'b1;
      end
      else if (rd_rx)
      begin
        rx_irq_flag <= 1'b0;
        rx_buffer_full <= 1'b0;
      end
      if (byte_done && rx_buffer_full && !rd_rx)
        rx_overflow_flag <= 1'b1;
      else if (rd_rx)
        rx_overflow_flag <= 1'b0;
      if (tx_pop && txq_cnt == 2'b01)
        tx_underflow <= 1'b1;
      else if (rd_stat || wr_tx)
        tx_underflow <= 1'b0;
      if (tx_pop)
        tx_irq_set <= 1'b1;
      else if (wr_tx)
        tx_irq_set <= 1'b0;
      if (is_master && ss_en && !ss_in && busy)
        multi_master_error <= 1'b1;
      else if (rd_stat)
        multi_master_error <= 1'b0;
    end
  end

  // plain mode shows not full, transfer mode shows the sticky event
  wire tx_irq_flag = transfer_mode_select ? (tx_irq_set && !tx_buffer_full) : !tx_buffer_full;
  wire rx_irq_show = rx_irq_flag && !transfer_mode_select;
  wire [7:0] status_word = {busy, multi_master_error, rx_overflow_flag, rx_irq_show,
    rx_buffer_full, tx_underflow, tx_irq_flag, tx_buffer_full};

  // read data register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sfr_rdata <= REG_RESET;
    else if (sfr_req.rd && sfr_req.addr == ADDR_CONFIG_ONE)
      sfr_rdata <= serial_config_one;
    else if (sfr_req.rd && sfr_req.addr == ADDR_CONFIG_TWO)
      sfr_rdata <= serial_config_two;
    else if (rd_stat)
      sfr_rdata <= status_word;
    else if (rd_rx)
      sfr_rdata <= receive_register;
    else if (sfr_req.rd)
      sfr_rdata <= REG_RESET;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      serial_irq <= 1'b0;
    else
      serial_irq <= serial_irq_enable && (rx_irq_show || (transfer_mode_select && tx_irq_flag));
  end

  // pin directions; enable low means driven
  assign pins.sclk_o = m_sclk;
  assign pins.sclk_oe_n = !is_master;
  assign pins.mosi_o = m_shift[BYTE_BITS - 1];
  assign pins.mosi_oe_n = !is_master;
  assign pins.miso_o = s_miso;
  assign pins.miso_oe_n = is_master || ss_in;
  assign pins.ss_o = m_ss;
  assign pins.ss_oe_n = !is_master || ss_en;
endmodule // spisf_core

// ==== verilog/spisf_pkg.sv ====
// package: register map, field positions and types of the serial flag block
package spisf_pkg;
  // special function register addresses
  localparam logic [7:0] ADDR_CONFIG_ONE = 8'h00e8;
  localparam logic [7:0] ADDR_CONFIG_TWO = 8'h00e9;
  localparam logic [7:0] ADDR_STATUS = 8'h00ea;
  localparam logic [7:0] ADDR_TX = 8'h009a;
  localparam logic [7:0] ADDR_RX = 8'h009b;
  // status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_MULTI_MASTER = 6;
  localparam int ST_RXOF = 5;
  localparam int ST_RXIRQ = 4;
  localparam int ST_RXBF = 3;
  localparam int ST_TXUF = 2;
  localparam int ST_TXIRQ = 1;
  localparam int ST_TXBF = 0;
  // config one fields
  localparam int C1_MASTER = 4;
  localparam int C1_AUTO_SS = 5;
  localparam int C1_SS_EN = 6;
  localparam int C1_DIV_LSB = 0;
  localparam int C1_DIV_W = 3;
  // config two fields
  localparam int C2_XFER_MODE = 0;
  localparam int C2_CPHA = 2;
  localparam int C2_CPOL = 3;
  localparam int C2_OVW = 4;
  localparam int C2_CONT = 7;
  localparam logic [7:0] REG_RESET = 8'h0000;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_COUNT_LAST = 4'h0008;
  localparam logic [7:0] DIV_BASE = 8'h0002;
  // bench link clock period, in ns
  localparam int LINK_PERIOD_NS = 15;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spisf_sfr_req_type;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe_n;
    logic mosi_o;
    logic mosi_oe_n;
    logic miso_o;
    logic miso_oe_n;
    logic ss_o;
    logic ss_oe_n;
  } spisf_pins_out_type;
endpackage
